// ==== csw_decoder.sv ====
// chip select and wait state decoder: apb config, decode, strobes
// assumes the cpu holds a request until cpu_ready, same clock
//
// Operation
// - control bit 4 picks memory or io
// - reset leaves every select in memory space
// - select asserts only when enabled
// - memory match: lower <= addr[23:16] <= upper
// - ram beats flash beats external selects
// - lowest numbered matching select wins
// - memory select only on memory access
// - internal memory hit keeps selects off
// - equal bounds cover one 64 KB page
// - select 0 bounds 00h-FFh, others 00h
// - io selects only on io instructions
// - io match on addr[15:8] equals base
// - io addresses 0000h-00FFh never select
// - io select drives io request, rd/wr
// - three bit wait count per select
// - wait count stalls exactly that many clocks
// - wait pin low stalls, resume after high
// - one wait state per clock while low
module csw_decoder
    import csw_pkg::*;
#(
    parameter int SELECTS = NUM_SELECTS          // external selects
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // cpu bus cycle
    input  wire logic                  cpu_req_valid,
    input  wire csw_req_type           cpu_req,
    input  wire logic                  cpu_ram_hit,
    input  wire logic                  cpu_flash_hit,
    output logic                       cpu_ready,
    // internal memory selects
    output logic                       int_ram_sel,
    output logic                       int_flash_sel,
    // external bus
    output csw_strobe_type             ext_strobe,
    input  wire logic                  wait_n
);

    // ==========================================================
    // functions

    // keep only the lowest set bit
    function automatic logic [NUM_SELECTS-1:0] lowest_onehot(
        input logic [NUM_SELECTS-1:0] req
    );
        logic [NUM_SELECTS-1:0] res;
        logic                   seen;
        res  = '0;
        seen = 1'b0;
        for (int i = 0; i < NUM_SELECTS; i++) begin
            if (req[i] && !seen) begin
                res[i] = 1'b1;
                seen   = 1'b1;
            end
        end
        return res;
    endfunction

    // turns every external select off when SELECTS exceeds NUM_SELECTS
    function automatic logic k_in_range(input int n);
        return n <= NUM_SELECTS;
    endfunction

    // inclusive bound check on one address byte
    function automatic logic in_bounds(
        input logic [7:0] value,
        input logic [7:0] low,
        input logic [7:0] high
    );
        return (value >= low) && (value <= high);
    endfunction

    // ==========================================================
    // configuration registers
    csw_ctl_type ctl   [NUM_SELECTS];            // per select control
    logic [7:0]  lower [NUM_SELECTS];            // memory lower bound
    logic [7:0]  upper [NUM_SELECTS];            // memory upper bound
    logic [7:0]  base  [NUM_SELECTS];            // io high byte base

    // ==========================================================
    // cycle state
    csw_state_type          state;               // fsm
    csw_state_type          next_state;
    logic [2:0]             wait_left;           // programmed waits left
    logic [2:0]             next_wait_left;
    logic                   ext_cycle;           // a select is out
    logic                   next_ext_cycle;
    csw_strobe_type         next_ext_strobe;
    logic                   next_int_ram_sel;
    logic                   next_int_flash_sel;
    logic                   wait_sync_n;         // wait pin, synced

    // ==========================================================
    // apb decode
    wire logic       apb_access = psel && penable;
    wire logic       apb_write  = apb_access && pwrite;
    wire logic [1:0] bank_idx   = paddr[5:4];
    wire logic [1:0] reg_idx    = paddr[3:2];
    wire logic       aligned    = (paddr[1:0] == 2'h0);
    wire logic       in_banks   = aligned &&
                                  (paddr < (REG_STRIDE * 12'(SELECTS)));
    wire logic       is_status  = (paddr == OFS_STATUS);
    wire logic       mapped     = in_banks || is_status;

    // every access finishes in its first access cycle
    assign pready  = 1'b1;
    // unmapped addresses answer with an error and read zero
    assign pslverr = apb_access && !mapped;

    // ==========================================================
    // read mux
    wire logic [7:0] bank_read =
        (reg_idx == IDX_CTL)   ? ctl[bank_idx]   :
        (reg_idx == IDX_LOWER) ? lower[bank_idx] :
        (reg_idx == IDX_UPPER) ? upper[bank_idx] :
                                 base[bank_idx];

    // status shows live strobes and wait pin, not stored values
    wire logic [7:0] status_read = {
        2'b00,
        (state == ST_ACCESS),
        ext_cycle && !wait_sync_n,
        ~ext_strobe.chip_select_n
    };

    wire logic [7:0] read_byte = in_banks  ? bank_read   :
                                 is_status ? status_read :
                                             8'h00;

    // read data is registered so it is stable in the access phase
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, read_byte};
        end
    end

    // ==========================================================
    // register writes, byte in the low lane, upper lanes ignored
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int k = 0; k < NUM_SELECTS; k++) begin
                // all selects start in memory space
                ctl[k]   <= (k == 0) ? CTL0_RESET : CTL_RESET;
                lower[k] <= LOWER_RESET;
                upper[k] <= (k == 0) ? UPPER0_RESET : UPPER_RESET;
                base[k]  <= BASE_RESET;
            end
        end else if (apb_write && in_banks) begin
            case (reg_idx)
                IDX_CTL:   ctl[bank_idx]   <= pwdata[7:0];
                IDX_LOWER: lower[bank_idx] <= pwdata[7:0];
                IDX_UPPER: upper[bank_idx] <= pwdata[7:0];
                default:   base[bank_idx]  <= pwdata[7:0];
            endcase
        end
    end

    // ==========================================================
    // address decode
    wire logic [7:0] page_byte  = cpu_req.addr[23:16]; // memory page
    wire logic [7:0] io_high    = cpu_req.addr[15:8];  // io high byte
    wire logic       mem_cycle  = !cpu_req.is_io;
    wire logic       io_cycle   = cpu_req.is_io;

    // on-chip ram first, then flash
    wire logic ram_take   = mem_cycle && cpu_ram_hit;
    wire logic flash_take = mem_cycle && cpu_flash_hit && !cpu_ram_hit;
    wire logic internal   = ram_take || flash_take;

    // on-chip peripheral registers own the bottom io page
    wire logic io_periph  = io_cycle && (io_high == IO_PERIPH_PAGE);

    logic [NUM_SELECTS-1:0] mem_match;           // memory candidates
    logic [NUM_SELECTS-1:0] io_match;            // io candidates

    // per select candidate terms; page and base are fully separate
    for (genvar k = 0; k < NUM_SELECTS; k++) begin : g_match
        wire logic en_k = ctl[k].select_enable;
        wire logic io_k = ctl[k].space_is_io;
        // equal bounds naturally give one 64 KB page
        assign mem_match[k] = en_k && !io_k && mem_cycle &&
                              in_bounds(page_byte, lower[k], upper[k]) &&
                              !internal;
        // address bits 23:16 and page offset play no part here
        assign io_match[k]  = en_k && io_k && io_cycle &&
                              (io_high == base[k]) &&
                              !io_periph;
    end

    // spaces never overlap, so the two vectors never both fire
    wire logic [NUM_SELECTS-1:0] winner =
        lowest_onehot(mem_match | io_match);
    wire logic [NUM_SELECTS-1:0] cfg_hit = (k_in_range(SELECTS)) ?
                                           winner : '0;
    wire logic                   any_sel = |cfg_hit;

    // wait count of the winning select
    logic [2:0] win_wait;
    always_comb begin
        win_wait = 3'h0;
        for (int k = 0; k < NUM_SELECTS; k++) begin
            if (cfg_hit[k]) begin
                win_wait = ctl[k].wait_count;
            end
        end
    end

    // ==========================================================
    // wait pin synchroniser
    csw_sync #(
        .IDLE_LEVEL (1'b1)
    ) u_wait_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (wait_n),
        .sync_out (wait_sync_n)
    );

    // ==========================================================
    // cycle control
    wire logic accept    = (state == ST_IDLE) && cpu_req_valid;
    // programmed waits first, then the pin may extend each clock
    wire logic hold_wait = ext_cycle && !wait_sync_n;
    wire logic finish    = (state == ST_ACCESS) &&
                           (wait_left == 3'h0) && !hold_wait;

    // ready is combinational so the cpu sees it in the last cycle
    assign cpu_ready = finish;

    // next state and strobes
    always_comb begin
        next_state         = state;
        next_wait_left     = wait_left;
        next_ext_cycle     = ext_cycle;
        next_ext_strobe    = ext_strobe;
        next_int_ram_sel   = int_ram_sel;
        next_int_flash_sel = int_flash_sel;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state      = ST_ACCESS;
                    // internal and peripheral cycles take no waits
                    next_wait_left  = any_sel ? win_wait : 3'h0;
                    next_ext_cycle  = any_sel;
                    next_ext_strobe.chip_select_n = ~cfg_hit;
                    // request strobe follows the space of the select
                    next_ext_strobe.memory_request_n =
                        !(any_sel && mem_cycle);
                    next_ext_strobe.io_request_n =
                        !(any_sel && io_cycle);
                    next_ext_strobe.read_n  =
                        !(any_sel && !cpu_req.is_write);
                    next_ext_strobe.write_n =
                        !(any_sel && cpu_req.is_write);
                    next_int_ram_sel   = ram_take;
                    next_int_flash_sel = flash_take;
                end
            end
            ST_ACCESS: begin
                if (wait_left != 3'h0) begin
                    // one programmed wait used per clock
                    next_wait_left = wait_left - 3'h1;
                end else if (finish) begin
                    // release everything when the cycle ends
                    next_state         = ST_IDLE;
                    next_ext_cycle     = 1'b0;
                    next_ext_strobe    = '1;
                    next_int_ram_sel   = 1'b0;
                    next_int_flash_sel = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state         <= ST_IDLE;
            wait_left     <= 3'h0;
            ext_cycle     <= 1'b0;
            ext_strobe    <= '1;
            int_ram_sel   <= 1'b0;
            int_flash_sel <= 1'b0;
        end else begin
            state         <= next_state;
            wait_left     <= next_wait_left;
            ext_cycle     <= next_ext_cycle;
            ext_strobe    <= next_ext_strobe;
            int_ram_sel   <= next_int_ram_sel;
            int_flash_sel <= next_int_flash_sel;
        end
    end

    // config changes during a cycle do not disturb it: decode and
    // wait count are taken once at accept, the trade being that a
    // write to the active select takes effect only on the next cycle

    // software must give wait pin users at least two programmed waits,
    // since the pin passes two stages before it is seen

endmodule

// ==== csw_pkg.sv ====
// shared constants and types for the chip select and wait state decoder
// assumes one system clock and a 32-bit apb register port
package csw_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_SELECTS = 4;              // external selects
    localparam int ADDR_W      = 24;             // cpu address width
    localparam int APB_ADDR_W  = 12;             // apb byte address
    localparam int SYNC_STAGES = 2;              // wait pin stages

    // ==========================================================
    // select control field positions
    localparam int CTL_WAIT_MSB = 7;             // wait count top
    localparam int CTL_WAIT_LSB = 5;             // wait count bottom
    localparam int CTL_IO_BIT   = 4;             // 1 = io space
    localparam int CTL_EN_BIT   = 3;             // 1 = enabled

    // ==========================================================
    // register map, byte addresses
    localparam logic [11:0] REG_STRIDE = 12'h010; // per select bank
    localparam logic [1:0]  IDX_CTL    = 2'h0;    // select_control
    localparam logic [1:0]  IDX_LOWER  = 2'h1;    // lower bound
    localparam logic [1:0]  IDX_UPPER  = 2'h2;    // upper bound
    localparam logic [1:0]  IDX_BASE   = 2'h3;    // io_select_base
    localparam logic [11:0] OFS_STATUS = 12'h040; // read-only status

    // status bit positions
    localparam int ST_ACTIVE_LSB = 0;            // [3:0] active selects
    localparam int ST_WAIT_BIT   = 4;            // wait pin held low
    localparam int ST_BUSY_BIT   = 5;            // cycle in progress

    // ==========================================================
    // reset values
    localparam logic [7:0] CTL0_RESET   = 8'h08; // select 0 enabled
    localparam logic [7:0] CTL_RESET    = 8'h00; // memory, disabled
    localparam logic [7:0] LOWER_RESET  = 8'h00;
    localparam logic [7:0] UPPER0_RESET = 8'hFF; // select 0 covers all
    localparam logic [7:0] UPPER_RESET  = 8'h00;
    localparam logic [7:0] BASE_RESET   = 8'h00;

    // io high byte owned by on-chip peripheral registers
    localparam logic [7:0] IO_PERIPH_PAGE = 8'h00;

    // ==========================================================
    // types
    typedef struct packed {
        logic [2:0] wait_count;                  // 0 to 7 wait states
        logic       space_is_io;                 // space choice
        logic       select_enable;               // select on
        logic [2:0] spare;                       // stored, unused
    } csw_ctl_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                 // cycle address
        logic              is_io;                // io instruction
        logic              is_write;             // write, else read
    } csw_req_type;

    typedef struct packed {
        logic [NUM_SELECTS-1:0] chip_select_n;   // external selects
        logic                   memory_request_n;
        logic                   io_request_n;
        logic                   read_n;
        logic                   write_n;
    } csw_strobe_type;

    typedef enum logic [0:0] {
        ST_IDLE,                                 // no cycle
        ST_ACCESS                                // strobes out
    } csw_state_type;

endpackage

// ==== csw_sync.sv ====
// two stage synchroniser for a level from outside the clock domain
// assumes the input is quasi static relative to core_clk
module csw_sync
    import csw_pkg::*;
#(
    parameter logic IDLE_LEVEL = 1'b1            // value held in reset
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    // ==========================================================
    // stages
    logic stage_first;                           // read by stage two only
    logic stage_second;                          // safe to use

    // first flop may go metastable, second settles it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stage_first  <= IDLE_LEVEL;
            stage_second <= IDLE_LEVEL;
        end else begin
            stage_first  <= async_in;
            stage_second <= stage_first;
        end
    end

    assign sync_out = stage_second;

endmodule

// ==== csw_decoder_properties.sv ====
// concurrent checks on the ports of the chip select decoder
// assumes one clock, srst synchronous active high, bound below
module csw_decoder_properties
    import csw_pkg::*;
(
    // clock and reset
    input wire logic           core_clk,
    input wire logic           srst,
    // cpu side
    input wire logic           cpu_ready,
    input wire csw_req_type    cpu_req,
    input wire logic           int_ram_sel,
    input wire logic           int_flash_sel,
    // external bus
    input wire csw_strobe_type ext_strobe,
    input wire logic           wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======
    // common clocking
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // high when some external select is asserted
    wire logic cs_on = !(&ext_strobe.chip_select_n);
    // ======
    // assertions
    AST_ONEHOT: assert property ($onehot0(~ext_strobe.chip_select_n))
        else $error("more than one select asserted");
    AST_ONE_SPACE: assert property (cs_on |->
        (ext_strobe.memory_request_n != ext_strobe.io_request_n) &&
        (ext_strobe.read_n != ext_strobe.write_n))
        else $error("select without exactly one space and direction strobe");
    AST_MEM_INSTR: assert property (!ext_strobe.memory_request_n |-> !cpu_req.is_io)
        else $error("memory request during io cycle");
    AST_IO_INSTR: assert property (!ext_strobe.io_request_n |->
        cpu_req.is_io && (cpu_req.addr[15:8] != 8'h00))
        else $error("io request outside io cycle or in peripheral page");
    AST_DIR: assert property (!ext_strobe.read_n |-> !cpu_req.is_write)
        else $error("read strobe on a write");
    AST_INT_PRIO: assert property ((int_ram_sel || int_flash_sel) |->
        (&ext_strobe.chip_select_n) && !(int_ram_sel && int_flash_sel))
        else $error("internal memory cycle with external select");
    AST_STROBE_HOLD: assert property ((cs_on && !cpu_ready) |=> $stable(ext_strobe))
        else $error("strobes changed before cycle end");
    AST_READY_GAP: assert property (cpu_ready |=> !cpu_ready && !cs_on)
        else $error("strobes not released after cycle end");
    AST_WAIT_STALL: assert property ((cs_on && !$past(wait_n, 2)) |-> !cpu_ready)
        else $error("cycle ended while wait held low");
    AST_CYCLE_ENDS: assert property ($fell(&ext_strobe.chip_select_n) |-> ##[0:20] cpu_ready)
        else $error("external cycle did not end");
    // ======
    // main scenarios
    COV_IO: cover property (!ext_strobe.io_request_n);
    COV_STALL: cover property (cs_on && !$past(wait_n, 2));
    COV_RAM: cover property (int_ram_sel);
endmodule

bind csw_decoder csw_decoder_properties u_props (
    .core_clk(core_clk), .srst(srst), .cpu_ready(cpu_ready), .cpu_req(cpu_req),
    .int_ram_sel(int_ram_sel), .int_flash_sel(int_flash_sel),
    .ext_strobe(ext_strobe), .wait_n(wait_n));

// ==== csw_ext_periph.sv ====
// slow external peripheral that stretches cycles with the wait pin
// assumes wait pin has a pull-up, so it reads high when not driven low
module csw_ext_periph (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // external bus
    input  wire logic [3:0] chip_select_n,
    input  wire logic [31:0] stall_cycles,  // 0 = never stalls
    output logic            wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic served;                           // stall already given
    int   left;                             // stall cycles remaining
    // ======
    // stall once per selected cycle, released level is the pull-up
    always @(posedge core_clk) begin
        if (srst || (&chip_select_n)) begin
            wait_n <= 1'b1;
            served <= 1'b0;
        end else if (!served) begin
            served <= 1'b1;
            left   <= stall_cycles;
            wait_n <= (stall_cycles == 0);
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            wait_n <= 1'b1;                 // bounded stall, never hangs the bus
        end
    end
endmodule

// ==== chip_select_wait_decoder_tb_top.sv ====
// self-checking bench for the chip select and wait state decoder
// assumes apb answers at once and cpu holds a request until ready
module chip_select_wait_decoder_tb_top;
    import csw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ======
    // signals
    logic           core_clk = 0;
    logic           srst = 1;
    logic           psel = 0, penable = 0, pwrite = 0;
    logic [11:0]    paddr = '0;
    logic [31:0]    pwdata = '0;
    logic [31:0]    prdata;
    logic           pready, pslverr;
    logic           cpu_req_valid = 0, cpu_ram_hit = 0, cpu_flash_hit = 0;
    csw_req_type    cpu_req = '0;
    logic           cpu_ready, int_ram_sel, int_flash_sel;
    csw_strobe_type ext_strobe;
    wire logic      wait_n;
    int             stall_cycles = 0;  // peripheral stall length
    int             fails = 0, n_tests = 0, cyc = 0;
    always #10 core_clk = ~core_clk;
    // ======
    // design and far side
    csw_decoder uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req),
        .cpu_ram_hit(cpu_ram_hit), .cpu_flash_hit(cpu_flash_hit), .cpu_ready(cpu_ready),
        .int_ram_sel(int_ram_sel), .int_flash_sel(int_flash_sel),
        .ext_strobe(ext_strobe), .wait_n(wait_n));
    csw_ext_periph u_periph (.core_clk(core_clk), .srst(srst),
        .chip_select_n(ext_strobe.chip_select_n), .stall_cycles(stall_cycles),
        .wait_n(wait_n));
    // ======
    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // watchdog: a hang counts as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    // ======
    // apb master: setup, access until pready, then release
    task automatic apb_rw(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                          output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= 32'(wd);
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb_rw(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb_rw(1'b0, a, 8'h00, rd, err);
        chk("prdata", 32'(exp), rd);
        chk("pslverr", 32'(exp_err), 32'(err));
    endtask
    // ======
    // one cpu cycle: strobes seen in the first access cycle, latency in cycles
    task automatic cpu_cycle(input logic [23:0] a, input logic io, wrt, ram, flash,
                             input logic [3:0] cs, input int lat);
        csw_strobe_type s;
        logic [1:0]     isel;
        logic           x;
        int             n;
        @(posedge core_clk);
        cpu_req_valid <= 1; cpu_req <= '{addr: a, is_io: io, is_write: wrt};
        cpu_ram_hit <= ram; cpu_flash_hit <= flash;
        @(posedge core_clk);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            if (n == 1) begin
                s = ext_strobe;
                isel = {int_ram_sel, int_flash_sel};
            end
        end while (cpu_ready !== 1'b1 && n < 40);
        @(posedge core_clk);
        cpu_req_valid <= 0; cpu_ram_hit <= 0; cpu_flash_hit <= 0;
        x = (cs != 4'hF);
        chk("strobes", 32'({cs, !(x && !io), !(x && io), !(x && !wrt), !(x && wrt)}), 32'(s));
        chk("internal", 32'({ram, flash && !ram}), 32'(isel));
        chk("latency", 32'(lat), 32'(n));
    endtask
    // ======
    // scenarios
    task automatic t_reset();
        for (int k = 0; k < 4; k++) begin
            rd_chk(12'(k * 16), (k == 0) ? 8'h08 : 8'h00, 1'b0);
            rd_chk(12'(k * 16 + 4), 8'h00, 1'b0);
            rd_chk(12'(k * 16 + 8), (k == 0) ? 8'hFF : 8'h00, 1'b0);
        end
        cpu_cycle(24'h12_3456, 1'b0, 1'b0, 1'b0, 1'b0, 4'hE, 1);
        cpu_cycle(24'hFF_0000, 1'b0, 1'b1, 1'b0, 1'b0, 4'hE, 1);
        cpu_cycle(24'h00_1200, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 1);
    endtask
    task automatic t_unmapped();
        rd_chk(12'h080, 8'h00, 1'b1);
        rd_chk(12'h002, 8'h00, 1'b1);
        // idle status: no select out, no cycle, no wait seen
        rd_chk(12'h040, 8'h00, 1'b0);
    endtask
    task automatic t_decode();
        wr(12'h008, 8'h7F);
        wr(12'h010, 8'h28);
        wr(12'h018, 8'h9F);
        wr(12'h020, 8'h48);
        wr(12'h024, 8'hA5);
        wr(12'h028, 8'hA5);
        wr(12'h030, 8'h78);
        wr(12'h03C, 8'h12);
        rd_chk(12'h030, 8'h78, 1'b0);
        cpu_cycle(24'h7F_FFFF, 1'b0, 1'b0, 1'b0, 1'b0, 4'hE, 1);
        cpu_cycle(24'h80_0000, 1'b0, 1'b1, 1'b0, 1'b0, 4'hD, 2);
        cpu_cycle(24'hA5_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hB, 3);
        cpu_cycle(24'hA5_FFFF, 1'b0, 1'b1, 1'b0, 1'b0, 4'hB, 3);
        cpu_cycle(24'hA4_FFFF, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1);
        cpu_cycle(24'hA6_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1);
        cpu_cycle(24'h12_3400, 1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 1);
        cpu_cycle(24'h12_3400, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 1);
        cpu_cycle(24'hFF_1234, 1'b1, 1'b0, 1'b0, 1'b0, 4'h7, 4);
        cpu_cycle(24'h00_1255, 1'b1, 1'b1, 1'b0, 1'b0, 4'h7, 4);
        cpu_cycle(24'h00_1334, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 1);
        cpu_cycle(24'h12_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hE, 1);
        wr(12'h010, 8'h20);
        wr(12'h03C, 8'h00);
        cpu_cycle(24'h80_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1);
        cpu_cycle(24'h00_0050, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 1);
        cpu_cycle(24'h00_00FF, 1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 1);
    endtask
    task automatic t_wait();
        wr(12'h020, 8'hE8);
        cpu_cycle(24'hA5_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'hB, 8);
        // pin low for 10 edges from the edge after select; ready two edges after release
        stall_cycles <= 10;
        cpu_cycle(24'hA5_0000, 1'b0, 1'b1, 1'b0, 1'b0, 4'hB, 14);
        stall_cycles <= 0;
    endtask
    // ======
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 0;
        t_reset();
        t_unmapped();
        t_decode();
        t_wait();
        final_report();
    end
endmodule
